//--- pkg/motor_ramp_pkg.sv
// Notes on behaviour
// R1: ramp target is startup limit plus 0/30/40/50 percent of normal limit.
// R2: each ramp step adds 1/2/5/10 percent of normal limit.
// R3: after sensorless entry and a 0-699 ms wait, step every 350 ms.
// R4: ramped current limit never exceeds the normal limit.
// R5: top speed codes 00..11 select 4096, 8192, 16384, 32768 rpm.
// R6: pickup duty is detected speed over top speed, halved.
// R7: in sensorless running speed is set only by limiting duty change.
// R8: duty update interval bit: 0 gives 2.7 ms, 1 gives 10.8 ms.
// R9: slew codes limit change per update; code 000 is open loop or 64/8.
// R10: dc excitation to forced commutation updates every 2.7 ms, soft-start limit.
// R11: acceleration and open loop use the selected interval and normal limit.
// R12: stable closed loop follows demand every 2.7 ms, still slew limited.
// R13: soft start without speed limitation rises 8 counts per 2.7 ms from 0.
// R14: duty is a 9-bit count in 1/512 steps, saturating at both ends.
`default_nettype none
package motor_ramp_pkg;

  // ==========================================================
  // register map and fields
  localparam logic [7:0] REG_SPEED_DIR   = 8'h0e;
  localparam logic [7:0] REG_DUTY_SLEW   = 8'h10;
  localparam logic [7:0] REG_RAMP_TIMING = 8'h11;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam int         TOPSPD_LSB      = 1;
  localparam int         SLEW_LSB        = 4;
  localparam int         START_LSB       = 1;
  localparam int         BOOST_LSB       = 6;
  localparam int         UPSTEP_LSB      = 4;
  localparam int         SS_SLEW_LSB     = 1;
  localparam int         UPTIME_BIT      = 0;

  // ==========================================================
  // timing, in ns as printed
  localparam int CLK_PERIOD_NS    = 40;
  localparam int DUTY_SHORT_NS    = 2_700_000;
  localparam int DUTY_LONG_NS     = 10_800_000;
  localparam int RAMP_STEP_NS     = 350_000_000;
  localparam int MS_NS            = 1_000_000;
  localparam logic [9:0] WAIT_MAX_MS = 10'h2bb;

  // ==========================================================
  // scales: duty in eighths of 1/512, current in half percent of normal
  localparam logic [11:0] DUTY_FS         = 12'hfff;
  localparam logic [7:0]  NORM_LIMIT      = 8'hc8;
  localparam logic [7:0]  START_UNIT      = 8'h19;
  localparam logic [6:0]  SOFT_FIXED_STEP = 7'h40;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_SOFT   = 3'b001,
    PH_ACCEL  = 3'b010,
    PH_STABLE = 3'b011,
    PH_OPEN   = 3'b100
  } phase_t;

  typedef enum logic [1:0] {
    RAMP_HOLD = 2'b00,
    RAMP_WAIT = 2'b01,
    RAMP_STEP = 2'b10,
    RAMP_DONE = 2'b11
  } ramp_st_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

  function automatic logic [6:0] slew_eighths(input logic [2:0] code);
    case (code)
      3'h1:    return 7'h02;
      3'h2:    return 7'h03;
      3'h3:    return 7'h04;
      3'h4:    return 7'h06;
      3'h5:    return 7'h0a;
      3'h6:    return 7'h14;
      3'h7:    return 7'h38;
      default: return 7'h40;
    endcase
  endfunction : slew_eighths

  function automatic logic [7:0] boost_units(input logic [1:0] code);
    case (code)
      2'h1:    return 8'h3c;
      2'h2:    return 8'h50;
      2'h3:    return 8'h64;
      default: return 8'h00;
    endcase
  endfunction : boost_units

  function automatic logic [7:0] step_units(input logic [1:0] code);
    case (code)
      2'h1:    return 8'h04;
      2'h2:    return 8'h0a;
      2'h3:    return 8'h14;
      default: return 8'h02;
    endcase
  endfunction : step_units

  function automatic logic [7:0] cap_limit(input logic [8:0] v, input logic [7:0] lim);
    return (v > {1'b0, lim}) ? lim : v[7:0];
  endfunction : cap_limit

endpackage : motor_ramp_pkg
`default_nettype wire

//--- verilog/motor_duty_ramp.sv
`timescale 1ns/10ps
`default_nettype none
module motor_duty_ramp import motor_ramp_pkg::*; #(
  parameter int DUTY_SHORT_CYC = DUTY_SHORT_NS / CLK_PERIOD_NS,
  parameter int DUTY_LONG_CYC  = DUTY_LONG_NS / CLK_PERIOD_NS,
  parameter int RAMP_STEP_CYC  = RAMP_STEP_NS / CLK_PERIOD_NS,
  parameter int MS_CYC         = MS_NS / CLK_PERIOD_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire cfg_req_t    cfg,
  output logic [7:0]       cfg_rdata,
  input  wire phase_t      phase,
  input  wire logic        speed_limit_en,
  input  wire logic        startup_current_reached,
  input  wire logic        sensorless_entry,
  input  wire logic        pickup_start,
  input  wire logic [15:0] pickup_rpm,
  input  wire logic [8:0]  duty_demand,
  input  wire logic [9:0]  ramp_wait_ms,
  output logic [8:0]       duty_out,
  output logic             duty_update,
  output logic [7:0]       current_limit
);

  // ==========================================================
  // configuration registers
  logic [7:0] spd_r, slew_r, tim_r, rdata_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      spd_r  <= CFG_RESET;
      slew_r <= CFG_RESET;
      tim_r  <= CFG_RESET;
    end else if (cfg.wr) begin
      if (cfg.addr == REG_SPEED_DIR)   spd_r  <= cfg.wdata;
      if (cfg.addr == REG_DUTY_SLEW)   slew_r <= cfg.wdata;
      if (cfg.addr == REG_RAMP_TIMING) tim_r  <= cfg.wdata;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= CFG_RESET;
    end else begin
      unique case (cfg.addr)
        REG_SPEED_DIR:   rdata_r <= spd_r;
        REG_DUTY_SLEW:   rdata_r <= slew_r;
        REG_RAMP_TIMING: rdata_r <= tim_r;
        default:         rdata_r <= CFG_RESET;
      endcase
    end
  end
  assign cfg_rdata = rdata_r;

  logic [1:0] top_sel, boost_sel, upstep_sel;
  logic [2:0] slew_sel, ss_slew_sel, start_sel;
  assign top_sel     = spd_r[TOPSPD_LSB +: 2];
  assign slew_sel    = slew_r[SLEW_LSB +: 3];
  assign start_sel   = slew_r[START_LSB +: 3];
  assign boost_sel   = tim_r[BOOST_LSB +: 2];
  assign upstep_sel  = tim_r[UPSTEP_LSB +: 2];
  assign ss_slew_sel = tim_r[SS_SLEW_LSB +: 3];

  // top speed is 4096 rpm shifted by the code, so the halved ratio
  // in eighths of 1/512 is a plain right shift of the detected speed
  function automatic logic [11:0] pickup_duty(input logic [15:0] rpm, input logic [1:0] sel);
    logic [15:0] v;
    v = rpm >> ({1'b0, sel} + 3'h1); // R5 R6
    return (v > {4'h0, DUTY_FS}) ? DUTY_FS : v[11:0];
  endfunction : pickup_duty

  function automatic logic [11:0] slew_to(input logic [11:0] cur, input logic [11:0] tgt,
                                          input logic [6:0] step, input logic unl);
    logic [11:0] s;
    s = {5'h00, step};
    if (unl)
      return tgt;
    if (tgt > cur)
      return (tgt - cur > s) ? cur + s : tgt;
    return (cur - tgt > s) ? cur - s : tgt;
  endfunction : slew_to

  // ==========================================================
  // duty update timing
  phase_t      phase_q_r;
  logic [18:0] upd_cnt_r;
  logic [18:0] interval_w;
  logic        phase_chg, soft_entry, upd_tick, uses_sel;

  assign phase_chg  = (phase != phase_q_r);
  assign soft_entry = phase_chg && (phase == PH_SOFT);
  assign uses_sel   = (phase == PH_ACCEL) || (phase == PH_OPEN); // R11
  assign interval_w = (uses_sel && tim_r[UPTIME_BIT]) ? 19'(DUTY_LONG_CYC)
                                                      : 19'(DUTY_SHORT_CYC); // R8 R10 R12
  // compare with >= so a shortened interval fires at once instead of waiting for a wrap
  assign upd_tick   = (phase != PH_IDLE) && !phase_chg && (upd_cnt_r >= interval_w - 19'h1);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q_r <= PH_IDLE;
      upd_cnt_r <= 19'h0;
    end else begin
      phase_q_r <= phase;
      // a phase change restarts the interval so a long one never leaks over
      if (phase_chg || upd_tick)
        upd_cnt_r <= 19'h0;
      else
        upd_cnt_r <= upd_cnt_r + 19'h1;
    end
  end

  // ==========================================================
  // duty slew
  logic [11:0] duty_acc_r, target_w;
  logic [6:0]  step_w;
  logic        unlimited_w, duty_update_r;

  always_comb begin
    if (phase == PH_SOFT) begin
      step_w   = speed_limit_en ? slew_eighths(ss_slew_sel) : SOFT_FIXED_STEP; // R10 R13
      target_w = startup_current_reached ? duty_acc_r : DUTY_FS; // R13
    end else begin
      step_w   = slew_eighths(slew_sel); // R9 R11
      target_w = {duty_demand, 3'h0}; // R12
    end
  end
  // code 000 lifts the limit only in open loop; closed loop treats it as 64/8
  assign unlimited_w = (phase == PH_OPEN) && (slew_sel == 3'h0); // R9

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      duty_acc_r <= 12'h000;
    end else if (pickup_start) begin
      duty_acc_r <= pickup_duty(pickup_rpm, top_sel); // R6
    end else if (soft_entry) begin
      duty_acc_r <= 12'h000; // R13
    end else if (upd_tick) begin
      duty_acc_r <= slew_to(duty_acc_r, target_w, step_w, unlimited_w); // R7 R14
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      duty_update_r <= 1'b0;
    else
      duty_update_r <= upd_tick && !pickup_start && !soft_entry;
  end
  // eighths are kept internally so fractional steps accumulate
  assign duty_out    = duty_acc_r[11:3]; // R14
  assign duty_update = duty_update_r;

  // ==========================================================
  // current limit ramp
  ramp_st_t    ramp_st_r;
  logic [24:0] ramp_cnt_r, wait_cyc_w;
  logic [7:0]  lim_r, start_w, ramp_tgt_w;
  logic [9:0]  wait_ms_w;

  assign start_w    = 8'(START_UNIT * (4'h8 - {1'b0, start_sel}));
  assign ramp_tgt_w = cap_limit({1'b0, start_w} + {1'b0, boost_units(boost_sel)},
                                NORM_LIMIT); // R1 R4
  assign wait_ms_w  = (ramp_wait_ms > WAIT_MAX_MS) ? WAIT_MAX_MS : ramp_wait_ms;
  assign wait_cyc_w = 25'({15'h0, wait_ms_w} * 25'(MS_CYC));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_st_r  <= RAMP_HOLD;
      ramp_cnt_r <= 25'h0;
      lim_r      <= 8'h00;
    end else if (pickup_start) begin
      // a spinning motor starts straight on the normal limit
      ramp_st_r <= RAMP_DONE;
      lim_r     <= NORM_LIMIT;
    end else if (soft_entry) begin
      ramp_st_r <= RAMP_HOLD;
      lim_r     <= start_w;
    end else if (sensorless_entry) begin
      ramp_st_r  <= RAMP_WAIT; // R3
      ramp_cnt_r <= 25'h0;
      lim_r      <= start_w;
    end else begin
      unique case (ramp_st_r)
        RAMP_HOLD: lim_r <= start_w;
        RAMP_WAIT: begin
          ramp_cnt_r <= ramp_cnt_r + 25'h1;
          if (ramp_cnt_r >= wait_cyc_w) begin
            ramp_st_r  <= RAMP_STEP; // R3
            ramp_cnt_r <= 25'h0;
          end
        end
        RAMP_STEP: begin
          ramp_cnt_r <= ramp_cnt_r + 25'h1;
          if (ramp_cnt_r == 25'(RAMP_STEP_CYC - 1)) begin
            ramp_cnt_r <= 25'h0;
            lim_r      <= cap_limit({1'b0, lim_r} + {1'b0, step_units(upstep_sel)},
                                    ramp_tgt_w); // R2 R3 R4
            if ({1'b0, lim_r} + {1'b0, step_units(upstep_sel)} >= {1'b0, ramp_tgt_w})
              ramp_st_r <= RAMP_DONE;
          end
        end
        RAMP_DONE: lim_r <= lim_r;
      endcase
    end
  end
  assign current_limit = lim_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ramp_armed;
    sensorless_entry && !pickup_start && !soft_entry;
  endsequence
  sequence s_ramp_wait;
    (ramp_st_r == RAMP_WAIT) && (lim_r == $past(start_w));
  endsequence

  a_limit_cap_normal: assert property (lim_r <= NORM_LIMIT) // R4
    else $error("current limit above normal limit");
  a_ramp_start_wait: assert property (s_ramp_armed |=> s_ramp_wait) // R3
    else $error("ramp did not start from startup limit");
  a_ramp_step_size: assert property ( // R2
    (ramp_st_r == RAMP_STEP) && (ramp_cnt_r == 25'(RAMP_STEP_CYC - 1)) && !pickup_start
    && !soft_entry && !sensorless_entry |=> lim_r == cap_limit({1'b0, $past(lim_r)}
    + {1'b0, step_units($past(upstep_sel))}, $past(ramp_tgt_w)))
    else $error("ramp step wrong");
  a_ramp_target_bound: assert property ((ramp_st_r == RAMP_DONE) // R1
    && ($past(ramp_st_r) == RAMP_STEP) && !$past(pickup_start)
    |-> lim_r == $past(ramp_tgt_w))
    else $error("ramp did not settle on boosted target");
  a_pickup_duty_set: assert property (pickup_start |=> // R6
    duty_acc_r == pickup_duty($past(pickup_rpm), $past(top_sel)))
    else $error("pickup duty wrong");
  a_soft_from_zero: assert property (soft_entry && !pickup_start |=> duty_acc_r == 12'h000 // R13
    ##1 duty_acc_r == 12'h000)
    else $error("soft start did not begin at zero");
  a_duty_hold_between: assert property (!upd_tick && !pickup_start && !soft_entry // R7
    |=> $stable(duty_acc_r))
    else $error("duty moved outside an update");
  a_slew_step_bound: assert property (duty_update_r && !$past(unlimited_w) |-> // R9
    ((duty_acc_r >= $past(duty_acc_r)) ? duty_acc_r - $past(duty_acc_r)
     : $past(duty_acc_r) - duty_acc_r) <= {5'h00, $past(step_w)})
    else $error("duty change exceeds slew limit");
  a_interval_short: assert property (!uses_sel && phase != PH_IDLE && !phase_chg // R10 R12
    |-> interval_w == 19'(DUTY_SHORT_CYC) && upd_cnt_r < 19'(DUTY_SHORT_CYC))
    else $error("short update interval wrong");
  a_interval_select: assert property (uses_sel && $stable(phase) |-> // R8 R11
    interval_w == (tim_r[UPTIME_BIT] ? 19'(DUTY_LONG_CYC) : 19'(DUTY_SHORT_CYC)))
    else $error("selected update interval wrong");

endmodule : motor_duty_ramp
`default_nettype wire

//--- testbench/motor_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module motor_stage_model #(
  parameter int REACH_COUNT = 100
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [8:0] duty_out,
  output logic            startup_current_reached
);
  // ==========================================================
  // stage current sense
  // current taken as proportional to duty; the shunt filter lags,
  // so the flag arrives one clock after the duty that causes it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      startup_current_reached <= 1'b0;
    end else begin
      startup_current_reached <= (duty_out >= 9'(REACH_COUNT));
    end
  end
endmodule : motor_stage_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top import motor_ramp_pkg::*;;
  logic sys_clk, reset_n, speed_limit_en, startup_current_reached;
  logic sensorless_entry, pickup_start, duty_update;
  cfg_req_t cfg;
  phase_t phase;
  logic [15:0] pickup_rpm;
  logic [8:0] duty_demand, duty_out;
  logic [9:0] ramp_wait_ms;
  logic [7:0] cfg_rdata, current_limit;
  logic [11:0] acc_exp;
  int fails, samples_checked, gap;
  int eighths[8] = '{64, 2, 3, 4, 6, 10, 20, 56};
  // ==========================================================
  // design and stage
  motor_duty_ramp #(.DUTY_SHORT_CYC(20), .DUTY_LONG_CYC(80), .RAMP_STEP_CYC(50),
    .MS_CYC(5)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg),
    .cfg_rdata(cfg_rdata), .phase(phase), .speed_limit_en(speed_limit_en),
    .startup_current_reached(startup_current_reached),
    .sensorless_entry(sensorless_entry), .pickup_start(pickup_start),
    .pickup_rpm(pickup_rpm), .duty_demand(duty_demand), .ramp_wait_ms(ramp_wait_ms),
    .duty_out(duty_out), .duty_update(duty_update), .current_limit(current_limit));
  motor_stage_model i_stage (.sys_clk(sys_clk), .reset_n(reset_n), .duty_out(duty_out),
    .startup_current_reached(startup_current_reached));
  // ==========================================================
  // helpers
  task automatic compare_val(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : compare_val
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d compares", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    cfg.wr = 1'b0;
  endtask : wr_reg
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    cfg.addr = a;
    repeat (2) @(negedge sys_clk);
    compare_val(16'(cfg_rdata), 16'(exp));
  endtask : rd_check
  // bounded wait for the next update; gap counts clocks since the call
  task automatic wait_upd();
    gap = 0;
    do begin
      @(negedge sys_clk);
      gap++;
    end while (duty_update !== 1'b1 && gap < 400);
    if (gap >= 400) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_upd
  task automatic enter(input phase_t p);
    @(negedge sys_clk);
    phase = PH_IDLE;
    @(negedge sys_clk);
    phase = p;
  endtask : enter
  // ==========================================================
  // scenarios
  task automatic sc_regs();
    logic [7:0] a[3] = '{REG_SPEED_DIR, REG_DUTY_SLEW, REG_RAMP_TIMING};
    foreach (a[i]) rd_check(a[i], 8'h00);
    foreach (a[i]) wr_reg(a[i], 8'h5a + 8'(i));
    wr_reg(8'h12, 8'hff);
    foreach (a[i]) rd_check(a[i], 8'h5a + 8'(i));
    rd_check(8'h12, 8'h00);
  endtask : sc_regs
  task automatic sc_soft();
    speed_limit_en = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr_reg(REG_RAMP_TIMING, 8'(c << 1));
      enter(PH_SOFT);
      repeat (8) wait_upd();
      compare_val(16'(duty_out), 16'(eighths[c]));
      compare_val(16'(gap), 16'h0014);
    end
    speed_limit_en = 1'b0;
    enter(PH_SOFT);
    wait_upd();
    compare_val(16'(duty_out), 16'h0008);
    repeat (15) wait_upd();
    compare_val(16'(duty_out), 16'h0068);
  endtask : sc_soft
  task automatic sc_pickup_slew();
    enter(PH_IDLE);
    for (int s = 0; s < 4; s++) begin
      wr_reg(REG_SPEED_DIR, 8'(s << 1));
      @(negedge sys_clk);
      pickup_start = 1'b1;
      @(negedge sys_clk);
      pickup_start = 1'b0;
      compare_val(16'(duty_out), 16'((3000 >> (s + 1)) >> 3));
      compare_val(16'(current_limit), 16'h00c8);
    end
    acc_exp = 12'h0bb;
    duty_demand = 9'h1ff;
    wr_reg(REG_RAMP_TIMING, 8'h01);
    phase = PH_STABLE;
    for (int k = 1; k < 9; k++) begin
      wr_reg(REG_DUTY_SLEW, 8'((k % 8) << 4));
      wait_upd();
      acc_exp = acc_exp + 12'(eighths[k % 8]);
      compare_val(16'(duty_out), 16'(acc_exp[11:3]));
    end
    wait_upd();
    compare_val(16'(gap), 16'h0014);
    duty_demand = 9'h064;
    enter(PH_OPEN);
    wait_upd();
    compare_val(16'(duty_out), 16'h0064);
    wait_upd();
    compare_val(16'(gap), 16'h0050);
    duty_demand = 9'h065;
    wr_reg(REG_DUTY_SLEW, 8'h70);
    wr_reg(REG_RAMP_TIMING, 8'h00);
    enter(PH_ACCEL);
    wait_upd();
    compare_val(16'(duty_out), 16'h0065);
    wait_upd();
    compare_val(16'(gap), 16'h0014);
  endtask : sc_pickup_slew
  task automatic sc_ramp();
    logic [7:0] r16[4] = '{8'h04, 8'h08, 8'h0c, 8'h0e};
    logic [7:0] r17[4] = '{8'hf0, 8'h60, 8'hb0, 8'h00};
    int st[4] = '{150, 100, 50, 25};
    int stp[4] = '{20, 10, 20, 2};
    int fin[4] = '{200, 160, 130, 25};
    enter(PH_IDLE);
    ramp_wait_ms = 10'h002;
    foreach (st[e]) begin
      wr_reg(REG_DUTY_SLEW, r16[e]);
      wr_reg(REG_RAMP_TIMING, r17[e]);
      @(negedge sys_clk);
      sensorless_entry = 1'b1;
      @(negedge sys_clk);
      sensorless_entry = 1'b0;
      compare_val(16'(current_limit), 16'(st[e]));
      for (int t = 0; t < 500; t++) begin
        @(negedge sys_clk);
        if (t == 5) compare_val(16'(current_limit), 16'(st[e]));
        if (current_limit > 8'(fin[e])) compare_val(16'(current_limit), 16'(fin[e]));
        if (current_limit != 8'(fin[e]))
          compare_val(16'((int'(current_limit) - st[e]) % stp[e]), 16'h0000);
      end
      compare_val(16'(current_limit), 16'(fin[e]));
    end
  endtask : sc_ramp
  // ==========================================================
  // clock, reset, sequence
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {reset_n, speed_limit_en, sensorless_entry, pickup_start} = '0;
    cfg = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
    phase = PH_IDLE;
    pickup_rpm = 16'h0bb8;
    duty_demand = 9'h000;
    ramp_wait_ms = 10'h000;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    sc_regs();
    sc_soft();
    sc_pickup_slew();
    sc_ramp();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
